/* File: ase_pkg.sv */
// shared constants and types for the abort syndrome encoder
// assumes nothing beyond a systemverilog compiler
package ase_pkg;
    localparam int SYN_W = 25;
    localparam int EC_W = 6;
    localparam int FSC_W = 6;
    localparam int IMM_W = 16;
    localparam int CALL_LO = 0;
    localparam int CALL_HI = 15;
    localparam int BIT_SYN_VALID = 24;
    localparam int SAS_LO = 22;
    localparam int BIT_SSE = 21;
    localparam int SRT_LO = 16;
    localparam int BIT_AR = 14;
    localparam int BIT_FNV = 10;
    localparam int BIT_EA = 9;
    localparam int BIT_CM = 8;
    localparam int BIT_WNR = 6;
    localparam logic [SYN_W-1:0] SYN_RESET = 25'h000_0000;
    localparam logic [EC_W-1:0] EC_RESET = 6'h00;
    localparam logic [EC_W-1:0] EC_SVC_TRAP = 6'h11;
    localparam logic [EC_W-1:0] EC_FETCH_ABT = 6'h20;
    localparam logic [EC_W-1:0] EC_FETCH_ABT_SAME = 6'h21;
    localparam logic [EC_W-1:0] EC_DATA_ABT = 6'h24;
    localparam logic [EC_W-1:0] EC_HVC = 6'h12;
    localparam logic [EC_W-1:0] EC_ILLEGAL = 6'h0e;
    localparam logic [EC_W-1:0] EC_PC_ALIGN = 6'h22;
    localparam logic [FSC_W-1:0] FSC_TRANSLATION = 6'h04;
    localparam logic [FSC_W-1:0] FSC_PERMISSION = 6'h0c;
    localparam logic [FSC_W-1:0] FSC_SYNC_EXT = 6'h10;
    localparam logic [FSC_W-1:0] FSC_SYNC_PARITY = 6'h18;
    localparam logic [FSC_W-1:0] FSC_ASYNC_ERR = 6'h11;
    localparam logic [FSC_W-1:0] FSC_ASYNC_PARITY = 6'h19;
    localparam logic [FSC_W-1:0] FSC_ALIGNMENT = 6'h21;
    localparam logic [FSC_W-1:0] FSC_DEBUG = 6'h22;
    localparam logic [FSC_W-1:0] FSC_LOCKDOWN = 6'h34;
    localparam logic [FSC_W-1:0] FSC_EXCLUSIVE = 6'h35;

    typedef enum logic [2:0] {
        ASE_KIND_NONE,
        ASE_KIND_HVC,
        ASE_KIND_SVC,
        ASE_KIND_FETCH,
        ASE_KIND_ILLEGAL,
        ASE_KIND_PC_ALIGN,
        ASE_KIND_DATA
    } ase_kind_t;

    typedef enum logic [1:0] {
        ASE_SIZE_BYTE,
        ASE_SIZE_HALF,
        ASE_SIZE_WORD,
        ASE_SIZE_DOUBLE
    } ase_size_t;
endpackage

/* File: ase_fault_if.sv */
// fault description passed from the top to the abort encoder
// assumes one producer and one consumer
`timescale 1ns/1ps
interface ase_fault_if;
    logic [ase_pkg::FSC_W-1:0] fault_code;
    logic fault_addr_invalid;
    logic ext_abort;
    logic ext_abort_class;
    logic is_data;
    logic stage2;
    logic single_reg;
    logic writeback;
    logic uses_pc;
    logic unpriv_form;
    logic debug_mem_mode;
    logic cache_maint;
    logic is_write;
    logic is_async;
    logic is_load;
    logic needs_sign;
    ase_pkg::ase_size_t access_size;
    logic [3:0] transfer_reg_num;
    logic acq_rel;
    logic [ase_pkg::SYN_W-1:0] syndrome;
    modport src (output fault_code, fault_addr_invalid, ext_abort, ext_abort_class, is_data,
                 stage2, single_reg, writeback, uses_pc, unpriv_form, debug_mem_mode,
                 cache_maint, is_write, is_async, is_load, needs_sign, access_size,
                 transfer_reg_num, acq_rel, input syndrome);
    modport enc (input fault_code, fault_addr_invalid, ext_abort, ext_abort_class, is_data,
                 stage2, single_reg, writeback, uses_pc, unpriv_form, debug_mem_mode,
                 cache_maint, is_write, is_async, is_load, needs_sign, access_size,
                 transfer_reg_num, acq_rel, output syndrome);
endinterface

/* File: ase_call_enc.sv */
// combinational syndrome for hypervisor and supervisor calls
// assumes the pipeline presents the raw immediate fields
`timescale 1ns/1ps
module ase_call_enc (
    // call description
    input wire logic is_hvc,
    input wire logic compact_isa,
    input wire logic conditional,
    input wire logic [15:0] hvc_imm,
    input wire logic [7:0] compact_imm,
    input wire logic [23:0] fixed_imm,
    // result
    output logic [ase_pkg::SYN_W-1:0] syndrome
);
    logic [ase_pkg::IMM_W-1:0] call_immediate;

    always_comb begin
        if (is_hvc) begin
            call_immediate = hvc_imm;
        end else if (conditional) begin
            call_immediate = 16'h0000;
        end else if (compact_isa) begin
            call_immediate = {8'h00, compact_imm};
        end else begin
            call_immediate = fixed_imm[ase_pkg::CALL_HI:0];
        end
        syndrome = ase_pkg::SYN_RESET;
        syndrome[ase_pkg::CALL_HI:ase_pkg::CALL_LO] = call_immediate;
    end
endmodule

/* File: ase_abort_enc.sv */
// combinational syndrome for fetch and data aborts
// assumes fault inputs are stable in the cycle the exception is taken
`timescale 1ns/1ps
module ase_abort_enc (
    // fault description and result
    ase_fault_if.enc flt
);
    logic qualifies;
    logic sync_ext;

    always_comb begin
        flt.syndrome = ase_pkg::SYN_RESET;
        sync_ext = (flt.fault_code == ase_pkg::FSC_SYNC_EXT);
        qualifies = flt.is_data && flt.stage2 && flt.single_reg && !flt.writeback
                    && !flt.uses_pc && !flt.unpriv_form;
        flt.syndrome[ase_pkg::FSC_W-1:0] = flt.fault_code;
        flt.syndrome[ase_pkg::BIT_FNV] = sync_ext && flt.fault_addr_invalid;
        flt.syndrome[ase_pkg::BIT_EA] = flt.ext_abort && flt.ext_abort_class;
        if (flt.is_data) begin
            flt.syndrome[ase_pkg::BIT_CM] = !flt.is_async && flt.cache_maint;
            flt.syndrome[ase_pkg::BIT_WNR] = flt.cache_maint || flt.is_write;
            // debug memory mode keeps the computed value, which is allowed
            if (qualifies) begin
                flt.syndrome[ase_pkg::BIT_SYN_VALID] = 1'b1;
                flt.syndrome[ase_pkg::SAS_LO+1:ase_pkg::SAS_LO] = flt.access_size;
                flt.syndrome[ase_pkg::BIT_SSE] = flt.is_load && flt.needs_sign
                    && (flt.access_size != ase_pkg::ASE_SIZE_DOUBLE);
                flt.syndrome[ase_pkg::SRT_LO+3:ase_pkg::SRT_LO] = flt.transfer_reg_num;
                flt.syndrome[ase_pkg::BIT_AR] = flt.acq_rel;
            end
        end
    end
endmodule

/* File: ase_top.sv */
// What this block does
// - calls: immediate low sixteen, upper zero
// - hypervisor call copies its sixteen-bit immediate
// - compact supervisor call zero-extends eight bits
// - fixed-width supervisor call takes low sixteen
// - conditional supervisor call immediate is free
// - fetch abort address-invalid bit, external only
// - external class bit zero unless external
// - fetch fault code carried in bits five:zero
// - fetch aborts recorded with class 0b100000, or 0b100001 when taken from the same level
// - rerouted supervisor calls use class 0b010001
// - illegal return, alignment: syndrome all zero
// - valid flag only for qualifying stage two
// - debug memory mode valid flag free
// - unprivileged fixed-width forms never valid
// - access size encoded in bits 23:22
// - sign extend for narrow signed loads
// - transfer register number in bits 19:16
// - acquire release flag in bit 14
// - valid-only fields zero without valid flag
// - data abort address-invalid bit, external only
// - cache maintenance bit for synchronous faults
// - direction bit, forced high for maintenance
// - data fault codes carried in bits five:zero
//
// top of the abort syndrome encoder
// assumes one-cycle take pulse from the pipeline, same clock
`timescale 1ns/1ps
module ase_top (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // exception take
    input wire logic take,
    input wire ase_pkg::ase_kind_t kind,
    input wire logic general_trap_ctrl,
    input wire logic same_level,
    input wire logic [31:0] fault_address,
    // call fields
    input wire logic compact_isa,
    input wire logic conditional,
    input wire logic [15:0] hvc_imm,
    input wire logic [7:0] compact_imm,
    input wire logic [23:0] fixed_imm,
    // abort fields
    input wire logic [ase_pkg::FSC_W-1:0] fault_code,
    input wire logic fault_addr_invalid,
    input wire logic ext_abort,
    input wire logic ext_abort_class,
    input wire logic stage2,
    input wire logic single_reg,
    input wire logic writeback,
    input wire logic uses_pc,
    input wire logic unpriv_form,
    input wire logic debug_mem_mode,
    input wire logic cache_maint,
    input wire logic is_write,
    input wire logic is_async,
    input wire logic is_load,
    input wire logic needs_sign,
    input wire ase_pkg::ase_size_t access_size,
    input wire logic [3:0] transfer_reg_num,
    input wire logic acq_rel,
    // register bus
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // recorded state
    output logic [ase_pkg::EC_W-1:0] exception_class,
    output logic [ase_pkg::SYN_W-1:0] instr_specific_syndrome,
    output logic [31:0] fetch_fault_address,
    output logic [31:0] data_fault_address,
    output logic recorded
);
    localparam logic [3:0] ADDR_SYN = 4'h0;
    localparam logic [3:0] ADDR_FETCH = 4'h4;
    localparam logic [3:0] ADDR_DATA = 4'h8;

    typedef struct packed {
        logic [ase_pkg::EC_W-1:0] ec;
        logic [ase_pkg::SYN_W-1:0] syn;
        logic [31:0] ifar;
        logic [31:0] dfar;
        logic [31:0] rdata;
        logic rec;
    } ase_state_t;

    ase_state_t st_r;
    ase_state_t st_nxt;
    logic [ase_pkg::SYN_W-1:0] call_syn;
    logic [ase_pkg::EC_W-1:0] ec_now;
    logic [ase_pkg::SYN_W-1:0] syn_now;

    ////////////////////////////////////////////////////////////////////////
    ase_fault_if flt ();

    assign flt.fault_code = fault_code;
    assign flt.fault_addr_invalid = fault_addr_invalid;
    assign flt.ext_abort = ext_abort;
    assign flt.ext_abort_class = ext_abort_class;
    assign flt.is_data = (kind == ase_pkg::ASE_KIND_DATA);
    assign flt.stage2 = stage2;
    assign flt.single_reg = single_reg;
    assign flt.writeback = writeback;
    assign flt.uses_pc = uses_pc;
    assign flt.unpriv_form = unpriv_form;
    assign flt.debug_mem_mode = debug_mem_mode;
    assign flt.cache_maint = cache_maint;
    assign flt.is_write = is_write;
    assign flt.is_async = is_async;
    assign flt.is_load = is_load;
    assign flt.needs_sign = needs_sign;
    assign flt.access_size = access_size;
    assign flt.transfer_reg_num = transfer_reg_num;
    assign flt.acq_rel = acq_rel;

    ase_abort_enc u_abort (
        .flt(flt)
    );

    ase_call_enc u_call (
        .is_hvc(kind == ase_pkg::ASE_KIND_HVC),
        .compact_isa(compact_isa),
        .conditional(conditional),
        .hvc_imm(hvc_imm),
        .compact_imm(compact_imm),
        .fixed_imm(fixed_imm),
        .syndrome(call_syn)
    );

    ////////////////////////////////////////////////////////////////////////
    // class and syndrome selection
    always_comb begin
        ec_now = ase_pkg::EC_RESET;
        syn_now = ase_pkg::SYN_RESET;
        unique case (kind)
            ase_pkg::ASE_KIND_NONE: begin
            end
            ase_pkg::ASE_KIND_HVC: begin
                ec_now = ase_pkg::EC_HVC;
                syn_now = call_syn;
            end
            ase_pkg::ASE_KIND_SVC: begin
                ec_now = ase_pkg::EC_SVC_TRAP;
                syn_now = call_syn;
            end
            ase_pkg::ASE_KIND_FETCH: begin
                ec_now = same_level ? ase_pkg::EC_FETCH_ABT_SAME
                                    : ase_pkg::EC_FETCH_ABT;
                syn_now = flt.syndrome;
            end
            ase_pkg::ASE_KIND_ILLEGAL: begin
                ec_now = ase_pkg::EC_ILLEGAL;
                syn_now = ase_pkg::SYN_RESET;
            end
            ase_pkg::ASE_KIND_PC_ALIGN: begin
                ec_now = ase_pkg::EC_PC_ALIGN;
                syn_now = ase_pkg::SYN_RESET;
            end
            ase_pkg::ASE_KIND_DATA: begin
                ec_now = ase_pkg::EC_DATA_ABT;
                syn_now = flt.syndrome;
            end
            default: begin
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // state update
    always_comb begin
        st_nxt = st_r;
        st_nxt.rdata = 32'h0000_0000;
        // software writes first so a same-cycle take wins
        if (reg_wr) begin
            unique case (reg_addr)
                ADDR_SYN: begin
                    st_nxt.ec = reg_wdata[31:26];
                    st_nxt.syn = reg_wdata[ase_pkg::SYN_W-1:0];
                end
                ADDR_FETCH: begin
                    st_nxt.ifar = reg_wdata;
                end
                ADDR_DATA: begin
                    st_nxt.dfar = reg_wdata;
                end
                default: begin
                end
            endcase
        end
        if (take && kind != ase_pkg::ASE_KIND_NONE) begin
            st_nxt.ec = ec_now;
            st_nxt.syn = syn_now;
            st_nxt.rec = 1'b1;
            if (kind == ase_pkg::ASE_KIND_FETCH) begin
                st_nxt.ifar = fault_address;
            end
            if (kind == ase_pkg::ASE_KIND_DATA) begin
                st_nxt.dfar = fault_address;
            end
        end
        if (reg_rd) begin
            unique case (reg_addr)
                ADDR_SYN: begin
                    st_nxt.rdata = {st_r.ec, 1'b1, st_r.syn};
                end
                ADDR_FETCH: begin
                    st_nxt.rdata = st_r.ifar;
                end
                ADDR_DATA: begin
                    st_nxt.rdata = st_r.dfar;
                end
                default: begin
                    st_nxt.rdata = 32'h0000_0000;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign reg_rdata = st_r.rdata;
    assign exception_class = st_r.ec;
    assign instr_specific_syndrome = st_r.syn;
    assign fetch_fault_address = st_r.ifar;
    assign data_fault_address = st_r.dfar;
    assign recorded = st_r.rec;
endmodule

/* File: ase_assertions.sv */
// concurrent checks on the abort syndrome encoder top
// assumes bind onto ase_top, one clock domain
`timescale 1ns/1ps
module ase_assertions (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // take side
    input wire logic take,
    input wire ase_pkg::ase_kind_t kind,
    input wire logic same_level,
    input wire logic compact_isa,
    input wire logic conditional,
    input wire logic [15:0] hvc_imm,
    input wire logic [7:0] compact_imm,
    input wire logic [5:0] fault_code,
    input wire logic ext_abort,
    input wire logic [31:0] fault_address,
    // register bus
    input wire logic [3:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    // recorded state
    input wire logic [5:0] exception_class,
    input wire logic [24:0] instr_specific_syndrome,
    input wire logic [31:0] data_fault_address
);
    logic hk, sk, fk, dk;
    logic [24:0] syn;
    assign hk = take && kind == ase_pkg::ASE_KIND_HVC;
    assign sk = take && kind == ase_pkg::ASE_KIND_SVC;
    assign fk = take && kind == ase_pkg::ASE_KIND_FETCH;
    assign dk = take && kind == ase_pkg::ASE_KIND_DATA;
    assign syn = instr_specific_syndrome;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);
    ////////////////////////////////////////
    a_hvc_imm: assert property (hk |=> syn == {9'h0, $past(hvc_imm)})
        else $error("hvc syndrome mismatch");
    a_call_high: assert property (sk |=> syn[24:16] == 9'h0)
        else $error("call upper bits not zero");
    a_compact_svc: assert property (sk && compact_isa && !conditional
        |=> syn == {17'h0, $past(compact_imm)}) else $error("compact call immediate");
    a_svc_class: assert property (sk |=> exception_class == 6'h11)
        else $error("call class wrong");
    a_fetch_class: assert property (fk && !same_level |=> exception_class == 6'h20)
        else $error("fetch class wrong");
    a_fetch_code: assert property (fk |=> syn[5:0] == $past(fault_code)
        && syn[24:11] == 14'h0 && syn[8:6] == 3'h0) else $error("fetch syndrome wrong");
    a_zero_syn: assert property (take && (kind == ase_pkg::ASE_KIND_ILLEGAL
        || kind == ase_pkg::ASE_KIND_PC_ALIGN) |=> syn == 25'h0) else $error("not zero");
    a_ext_zero: assert property ((fk || dk) && !ext_abort |=> !syn[9])
        else $error("external class set");
    a_data_addr: assert property (dk |=> data_fault_address == $past(fault_address))
        else $error("data address not captured");
    a_hold_syn: assert property (!take && !reg_wr |=> $stable(syn))
        else $error("syndrome moved");
    a_read_back: assert property (reg_rd && reg_addr == 4'h0 && !take
        |=> reg_rdata == {exception_class, 1'b1, syn}) else $error("read back wrong");
    a_valid_gate: assert property (dk |=> syn[24] || syn[23:14] == 10'h0)
        else $error("syndrome fields set without valid flag");
    a_fnv_gate: assert property ((fk || dk) && fault_code != 6'h10 |=> !syn[10])
        else $error("address invalid bit set for non-external code");
    c_hvc: cover property (hk);
    c_fetch: cover property (fk);
    c_valid: cover property (dk ##1 syn[24]);
endmodule
bind ase_top ase_assertions u_chk (.clk, .srst, .take, .kind, .same_level, .compact_isa,
    .conditional, .hvc_imm, .compact_imm, .fault_code, .ext_abort, .fault_address,
    .reg_addr, .reg_wr, .reg_rd, .reg_rdata, .exception_class, .instr_specific_syndrome,
    .data_fault_address);

/* File: test_abort_syndrome_encoder.sv */
// self-checking bench for the abort syndrome encoder
// assumes package, interface and design files compiled first
`timescale 1ns/1ps
module test_abort_syndrome_encoder;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic take = 1'b0;
    ase_pkg::ase_kind_t kind = ase_pkg::ASE_KIND_NONE;
    ase_pkg::ase_size_t access_size = ase_pkg::ASE_SIZE_BYTE;
    logic general_trap_ctrl, same_level, compact_isa, conditional, fault_addr_invalid;
    logic ext_abort, ext_abort_class, stage2, single_reg, writeback, uses_pc, unpriv_form;
    logic debug_mem_mode, cache_maint, is_write, is_async, is_load, needs_sign, acq_rel;
    logic [31:0] fault_address, reg_wdata, reg_rdata, fetch_fault_address, data_fault_address;
    logic [15:0] hvc_imm;
    logic [7:0] compact_imm;
    logic [23:0] fixed_imm;
    logic [5:0] fault_code, exception_class, exp_cls;
    logic [3:0] transfer_reg_num, reg_addr;
    logic reg_wr, reg_rd, recorded;
    logic [24:0] instr_specific_syndrome, exp_syn, msk;
    logic [31:0] exp_reg [4];
    int err_count = 0;
    int num_checks = 0;
    localparam logic [5:0] CODES [10] = '{6'h04, 6'h0c, 6'h10, 6'h18, 6'h11, 6'h19,
        6'h21, 6'h22, 6'h34, 6'h35};

    always #2 clk = ~clk;

    ase_top dut (.clk, .srst, .take, .kind, .general_trap_ctrl, .same_level, .fault_address,
        .compact_isa, .conditional, .hvc_imm, .compact_imm, .fixed_imm, .fault_code,
        .fault_addr_invalid, .ext_abort, .ext_abort_class, .stage2, .single_reg, .writeback,
        .uses_pc, .unpriv_form, .debug_mem_mode, .cache_maint, .is_write, .is_async, .is_load,
        .needs_sign, .access_size, .transfer_reg_num, .acq_rel, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .exception_class, .instr_specific_syndrome, .fetch_fault_address,
        .data_fault_address, .recorded);
    ////////////////////////////////////////
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic put(input logic [31:0] r);
        {compact_isa, conditional, same_level, general_trap_ctrl, fault_addr_invalid,
            ext_abort, ext_abort_class, debug_mem_mode, cache_maint, is_write, is_async,
            is_load, needs_sign, acq_rel, stage2, single_reg, writeback, uses_pc, unpriv_form,
            transfer_reg_num} <= r[22:0];
        access_size <= ase_pkg::ase_size_t'(r[24:23]);
    endtask

    task automatic model();
        logic v;
        v = stage2 && single_reg && !writeback && !uses_pc && !unpriv_form;
        exp_syn = 25'h000_0000;
        msk = '1;
        case (kind)
            ase_pkg::ASE_KIND_HVC: begin
                exp_cls = 6'h12;
                exp_syn[15:0] = hvc_imm;
            end
            ase_pkg::ASE_KIND_SVC: begin
                exp_cls = 6'h11;
                if (!conditional) exp_syn[15:0] = compact_isa ? {8'h00, compact_imm} : fixed_imm[15:0];
            end
            ase_pkg::ASE_KIND_ILLEGAL: exp_cls = 6'h0e;
            ase_pkg::ASE_KIND_PC_ALIGN: exp_cls = 6'h22;
            default: begin
                exp_cls = kind == ase_pkg::ASE_KIND_DATA ? 6'h24 : (same_level ? 6'h21 : 6'h20);
                exp_syn[5:0] = fault_code;
                exp_syn[10] = fault_addr_invalid && fault_code == 6'h10;
                exp_syn[9] = ext_abort && ext_abort_class;
                exp_reg[kind == ase_pkg::ASE_KIND_DATA ? 2 : 1] = fault_address;
            end
        endcase
        if (kind == ase_pkg::ASE_KIND_DATA) begin
            exp_syn[24] = v;
            exp_syn[8] = cache_maint;
            exp_syn[6] = cache_maint || is_write;
            if (is_async) msk = 25'h1ff_febf;
            if (v) begin
                exp_syn[23:22] = access_size;
                exp_syn[21] = is_load && needs_sign && access_size != ase_pkg::ASE_SIZE_DOUBLE;
                exp_syn[19:16] = transfer_reg_num;
                exp_syn[14] = acq_rel;
            end
        end
        exp_reg[0] = {exp_cls, 1'b1, exp_syn};
    endtask

    task automatic do_take(input ase_pkg::ase_kind_t k, input int i);
        logic [31:0] r;
        r = $urandom;
        // every kind sees qualifying and plain aborts, and every fault code
        if ((i / 6) % 2 == 0) r[8:4] = 5'b11000;
        r[18] = i[2];
        @(posedge clk);
        take <= 1'b1;
        kind <= k;
        put(r);
        fault_code <= CODES[(i / 2) % 10];
        {hvc_imm, compact_imm} <= 24'($urandom);
        fixed_imm <= 24'($urandom);
        fault_address <= $urandom;
        @(posedge clk);
        take <= 1'b0;
        #1;
        if (k != ase_pkg::ASE_KIND_NONE) model();
        check(exception_class, exp_cls);
        check(instr_specific_syndrome & msk, exp_syn & msk);
        check(fetch_fault_address, exp_reg[1]);
        check(data_fault_address, exp_reg[2]);
        check(recorded, 1'b1);
    endtask

    task automatic rd(input int a, input logic [31:0] m);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= 4'(a * 4);
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        check(reg_rdata & m, exp_reg[a] & m);
    endtask

    task automatic wr(input int a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= 4'(a * 4);
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        if (a != 3) exp_reg[a] = d;
        // bit 25 of the syndrome word always reads back as one
        if (a == 0) exp_reg[0][25] = 1'b1;
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////
    initial begin
        void'($urandom(54979));
        put(32'h0000_0000);
        {hvc_imm, compact_imm, fixed_imm, fault_address, reg_wdata, fault_code, reg_addr} = '0;
        {reg_wr, reg_rd} = 2'b00;
        exp_reg = '{4{32'h0000_0000}};
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        #1;
        check(instr_specific_syndrome, 32'h0000_0000);
        check({recorded, exception_class}, 32'h0000_0000);
        $display("test reset done");
        for (int i = 0; i < 72; i++) begin
            do_take(ase_pkg::ase_kind_t'(1 + i % 6), i);
            for (int a = 0; a < 4; a++) rd(a, a == 0 ? {7'h7f, msk} : '1);
        end
        $display("test takes done");
        do_take(ase_pkg::ase_kind_t'(0), 3);
        $display("test ignored kind done");
        wr(3, $urandom);
        rd(3, '1);
        wr(0, $urandom);
        rd(0, '1);
        wr(1, $urandom);
        wr(2, $urandom);
        rd(1, '1);
        rd(2, '1);
        $display("test register writes done");
        give_verdict();
    end
endmodule
